// ### global_status_pkg.sv
/*
  Constants, codes and carriers for the global status, interrupt
  summary and general-purpose pin block.
  Assumes a single 250 MHz system clock and word-wide Avalon-MM access.
*/
// Summary of operation
// - pin selector: input, LOS, zero, one
// - A1/B1 port1, A2/B2 port2, A3/B3 port3, B4 port4
// - B3 outputs one-second reference when enabled
// - B2 is error-insert input when selected
// - B1 is update input in mode 01
// - port summary set when port has enabled status
// - global summary set on enabled latched status
// - summary bit interrupts only when enabled
// - live unlocked bit follows clock adapter lock
// - update done when requested and all global-mode ports done
// - clock A/B/C latches set on toggle, adapter mode off only
// - reference clock latch set on toggle, adapter mode not off only
// - unlocked latch set on rising live bit
// - one-second latch set on timer rise
// - update-done latch set on status rise
// - latch enables: bit2 lock, 1 second, 0 done
// - pin status: A pins 7:4, B pins 3:0
// - latches clear on write or on read
// - irq pin low when active, else idle mode
package global_status_pkg;

  // byte offsets of the register words
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_GIOCR  = 6'h10;
  localparam logic [5:0] OFS_ISR    = 6'h20;
  localparam logic [5:0] OFS_ISRIE  = 6'h24;
  localparam logic [5:0] OFS_SR     = 6'h28;
  localparam logic [5:0] OFS_SRIE   = 6'h2C;
  localparam logic [5:0] OFS_SRL    = 6'h30;
  localparam logic [5:0] OFS_PIN    = 6'h34;

  // control word fields
  localparam int CTL_CLR_ON_READ = 0;
  localparam int CTL_IRQ_IDLE    = 1;
  localparam int CTL_SEC_OE      = 2;
  localparam int CTL_ERR_SRC     = 3;
  localparam int CTL_UPD_MODE    = 4;
  localparam int CTL_UPD_REQ     = 6;
  localparam int CTL_ERR_INS     = 7;
  localparam int CTL_ADP_MODE    = 8;

  // writable bits and reset values
  localparam logic [15:0] CTRL_MASK  = 16'h07FF;
  localparam logic [15:0] ISRIE_MASK = 16'h001F;
  localparam logic [15:0] SRIE_MASK  = 16'h0007;
  localparam logic [15:0] RST_CTRL   = 16'h0000;
  localparam logic [15:0] RST_GIOCR  = 16'h0000;
  localparam logic [15:0] RST_ISRIE  = 16'h0000;
  localparam logic [15:0] RST_SRIE   = 16'h0000;

  // latched and live status bit positions
  localparam int SRL_UPD  = 0;
  localparam int SRL_SEC  = 1;
  localparam int SRL_UNLK = 2;
  localparam int SRL_REF  = 3;
  localparam int SRL_ADAPTER_CLOCK_A = 4;
  localparam int SR_UPD   = 0;
  localparam int SR_UNLK  = 2;
  localparam int SRL_W    = 7;

  // pin status and selector layout
  localparam int PIN_A_LO = 4;
  localparam int PIN_B_LO = 0;
  localparam int SEL_A_LO = 8;
  localparam int SEL_B_LO = 0;

  // pin function and update mode codes
  localparam logic [1:0] FN_INPUT = 2'h0;
  localparam logic [1:0] FN_LOS   = 2'h1;
  localparam logic [1:0] FN_ZERO  = 2'h2;
  localparam logic [1:0] FN_ONE   = 2'h3;
  localparam logic [1:0] UPD_SW   = 2'h0;
  localparam logic [1:0] UPD_PIN  = 2'h1;
  localparam logic [2:0] ADP_OFF  = 3'h0;

  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

  // eight general-purpose pins; index 0 is pin 1
  typedef struct packed {
    logic [3:0] a;
    logic [3:0] b;
  } gpio_bus_s;

endpackage

// ### pin_sync.sv
/*
  Two-flop synchroniser for a vector of asynchronous pin levels.
  Assumes each bit is an independent level; no bus coherence.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 12
) (
  input  wire logic         sys_clk, // system clock
  input  wire logic         sys_rst, // async reset, high
  input  wire logic [W-1:0] din,     // raw pin levels
  output logic      [W-1:0] dout     // synchronised levels
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ### global_status_gpio_control.sv
/*
  Global status, interrupt summary and general-purpose pin logic,
  with its registers on an Avalon-MM slave with waitrequest.
  Assumes port status, LOS, update-done and lock inputs come from
  logic on sys_clk; gpio and adapter clock pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module global_status_gpio_control
  import global_status_pkg::*;
#(
  parameter int PORTS = 4
) (
  input  wire logic        sys_clk,          // system clock
  input  wire logic        sys_rst,          // async reset, high
  input  wire logic [3:0]  avs_address,      // word address
  input  wire logic        avs_read,         // read request
  input  wire logic        avs_write,        // write request
  input  wire logic [31:0] avs_writedata,    // write data
  input  wire logic [3:0]  avs_byteenable,   // byte lanes
  output logic      [31:0] avs_readdata,     // read data
  output logic             avs_waitrequest,  // stall
  input  wire logic [PORTS-1:0] port_los,    // per-port LOS
  input  wire logic [PORTS-1:0] port_irq_active,  // port status
  input  wire logic [PORTS-1:0] port_update_mode, // 1 = global
  input  wire logic [PORTS-1:0] port_update_done, // port done
  input  wire logic        adapter_unlocked, // adapter not locked
  input  wire logic        one_second_ref,   // internal timer
  input  wire logic        adapter_reference_clock, // pin
  input  wire logic        adapter_clock_a,  // pin
  input  wire logic        adapter_clock_b,  // pin
  input  wire logic        adapter_clock_c,  // pin
  input  wire gpio_bus_s   gpio_in,          // pin levels
  output gpio_bus_s        gpio_out,         // pin drive values
  output gpio_bus_s        gpio_oe,          // pin enables
  output logic             manual_error_insert,   // to ports
  output logic             global_update_request, // to ports
  output logic             irq_n_out,        // irq pin value
  output logic             irq_n_oe          // irq pin enable
);

  bus_state_e  bus_q;
  logic [31:0] rdata_q;
  logic [15:0] ctrl_q;
  logic [15:0] giocr_q;
  logic [15:0] isrie_q;
  logic [15:0] srie_q;
  logic [SRL_W-1:0] srl_q;
  logic        unlocked_q;
  logic        unlocked_prev_q;
  logic        sec_prev_q;
  logic        done_q;
  logic        irq_q;
  logic [3:0]  clk_prev_q;
  logic [11:0] sync_s;
  gpio_bus_s   gpio_s;
  logic [3:0]  clk_s;
  logic [3:0]  clk_tog;
  logic [5:0]  byte_addr;
  logic        take;
  logic        wr_take;
  logic        rd_take;
  logic [31:0] rdata_d;
  logic        upd_level;
  logic        done_d;
  logic        adp_off;
  logic [SRL_W-1:0] srl_set;
  logic [SRL_W-1:0] srl_clr;
  logic        global_summary_status;
  logic [4:0]  isr;
  gpio_bus_s   out_d;
  gpio_bus_s   oe_d;

  // register hit for a given offset
  function automatic logic hit(input logic [5:0] a,
                               input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  // merge write data into a 16-bit register by byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [15:0] msk);
    logic [15:0] n;
    n = old;
    if (be[0]) n[7:0] = wd[7:0];
    if (be[1]) n[15:8] = wd[15:8];
    merge16 = n & msk;
  endfunction

  // pin drive {oe, value} for a selector code
  function automatic logic [1:0] pin_fn(input logic [1:0] code,
                                        input logic       los);
    case (code)
      FN_INPUT: pin_fn = 2'b00;
      FN_LOS:   pin_fn = {1'b1, los};
      FN_ZERO:  pin_fn = 2'b10;
      default:  pin_fn = 2'b11;
    endcase
  endfunction

  // asynchronous pins: gpio levels and adapter clock pins
  pin_sync #(
    .W (12)
  ) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .din     ({adapter_reference_clock, adapter_clock_c,
               adapter_clock_b, adapter_clock_a,
               gpio_in}),
    .dout    (sync_s)
  );

  assign gpio_s  = sync_s[7:0];
  assign clk_s   = sync_s[11:8];
  assign clk_tog = clk_s ^ clk_prev_q;
  assign adp_off = (ctrl_q[CTL_ADP_MODE +: 3] == ADP_OFF);

  // bus handshake: one stall cycle, then answer
  assign byte_addr       = {avs_address, 2'b00};
  assign take            = (bus_q == BUS_ACK);
  assign wr_take         = take & avs_write;
  assign rd_take         = take & avs_read;
  assign avs_waitrequest = (avs_read | avs_write) & ~take;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_q <= BUS_IDLE;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (avs_read | avs_write) bus_q <= BUS_ACK;
        end
        BUS_ACK:  bus_q <= BUS_IDLE;
        default:  bus_q <= BUS_IDLE;
      endcase
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (byte_addr)
      OFS_CTRL:  rdata_d[15:0] = ctrl_q;
      OFS_GIOCR: rdata_d[15:0] = giocr_q;
      OFS_ISR:   rdata_d[4:0]  = isr;
      OFS_ISRIE: rdata_d[15:0] = isrie_q;
      OFS_SR: begin
        rdata_d[SR_UNLK] = unlocked_q;
        rdata_d[SR_UPD]  = done_q;
      end
      OFS_SRIE:  rdata_d[15:0] = srie_q;
      OFS_SRL:   rdata_d[SRL_W-1:0] = srl_q;
      OFS_PIN: begin
        rdata_d[PIN_A_LO +: 4] = gpio_s.a;
        rdata_d[PIN_B_LO +: 4] = gpio_s.b;
      end
      default:   rdata_d = 32'h0000_0000;
    endcase
  end

  // data captured in the stall cycle, shown in the answer cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_q == BUS_IDLE && avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  // software-written configuration words
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q  <= RST_CTRL;
      giocr_q <= RST_GIOCR;
      isrie_q <= RST_ISRIE;
      srie_q  <= RST_SRIE;
    end else if (wr_take) begin
      if (hit(byte_addr, OFS_CTRL))
        ctrl_q <= merge16(ctrl_q, avs_writedata, avs_byteenable,
                          CTRL_MASK);
      if (hit(byte_addr, OFS_GIOCR))
        giocr_q <= merge16(giocr_q, avs_writedata, avs_byteenable,
                           16'hFFFF);
      if (hit(byte_addr, OFS_ISRIE))
        isrie_q <= merge16(isrie_q, avs_writedata, avs_byteenable,
                           ISRIE_MASK);
      if (hit(byte_addr, OFS_SRIE))
        srie_q <= merge16(srie_q, avs_writedata, avs_byteenable,
                          SRIE_MASK);
    end
  end

  // update request level from the selected source
  always_comb begin
    case (ctrl_q[CTL_UPD_MODE +: 2])
      UPD_SW:  upd_level = ctrl_q[CTL_UPD_REQ];
      UPD_PIN: upd_level = gpio_s.b[0];
      default: upd_level = one_second_ref;
    endcase
  end

  // done only while requested; ports on local update ignored
  assign done_d = upd_level &
                  (&(port_update_done | ~port_update_mode));

  // live status and edge history
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlocked_q      <= 1'b0;
      unlocked_prev_q <= 1'b0;
      sec_prev_q      <= 1'b0;
      done_q          <= 1'b0;
      clk_prev_q      <= 4'h0;
    end else begin
      unlocked_q      <= adapter_unlocked;
      unlocked_prev_q <= unlocked_q;
      sec_prev_q      <= one_second_ref;
      done_q          <= done_d;
      clk_prev_q      <= clk_s;
    end
  end

  // latch set events
  always_comb begin
    srl_set = '0;
    srl_set[SRL_ADAPTER_CLOCK_A +: 3] = clk_tog[2:0] & {3{adp_off}};
    srl_set[SRL_REF]  = clk_tog[3] & ~adp_off;
    srl_set[SRL_UNLK] = unlocked_q & ~unlocked_prev_q;
    srl_set[SRL_SEC]  = one_second_ref & ~sec_prev_q;
    srl_set[SRL_UPD]  = done_d & ~done_q;
  end

  // clear by write-one or by read; only bits that were reported
  always_comb begin
    srl_clr = '0;
    if (hit(byte_addr, OFS_SRL)) begin
      if (wr_take && !ctrl_q[CTL_CLR_ON_READ] && avs_byteenable[0])
        srl_clr = avs_writedata[SRL_W-1:0];
      if (rd_take && ctrl_q[CTL_CLR_ON_READ])
        srl_clr = rdata_q[SRL_W-1:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      srl_q <= '0;
    end else begin
      srl_q <= srl_set | (srl_q & ~srl_clr);
    end
  end

  // interrupt summary tree
  assign global_summary_status = |(srl_q[2:0] & srie_q[2:0]);
  assign isr = {port_irq_active, global_summary_status};

  // registered so the pin never glitches on decode
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(isr & isrie_q[4:0]);
    end
  end

  // low while active; idle is float or drive-high
  assign irq_n_out = ~irq_q;
  assign irq_n_oe  = irq_q | ctrl_q[CTL_IRQ_IDLE];

  // per-pin function, then global overrides on B1..B3
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      {oe_d.a[i], out_d.a[i]} =
        pin_fn(giocr_q[SEL_A_LO + 2*i +: 2], port_los[i]);
      {oe_d.b[i], out_d.b[i]} =
        pin_fn(giocr_q[SEL_B_LO + 2*i +: 2], port_los[i]);
    end
    if (ctrl_q[CTL_SEC_OE]) begin
      oe_d.b[2]  = 1'b1;
      out_d.b[2] = one_second_ref;
    end
    if (ctrl_q[CTL_ERR_SRC]) begin
      oe_d.b[1]  = 1'b0;
      out_d.b[1] = 1'b0;
    end
    if (ctrl_q[CTL_UPD_MODE +: 2] == UPD_PIN) begin
      oe_d.b[0]  = 1'b0;
      out_d.b[0] = 1'b0;
    end
  end

  // pin and global strobe outputs from flops
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpio_out              <= '0;
      gpio_oe               <= '0;
      manual_error_insert   <= 1'b0;
      global_update_request <= 1'b0;
    end else begin
      gpio_out <= out_d;
      gpio_oe  <= oe_d;
      manual_error_insert <= ctrl_q[CTL_ERR_SRC] ?
                             gpio_s.b[1] :
                             ctrl_q[CTL_ERR_INS];
      global_update_request <= upd_level;
    end
  end

endmodule // global_status_gpio_control
`default_nettype wire

// ### global_status_gpio_control_monitor.sv
/* Port checker for the global status and pin block.
   Assumes full byte lanes on writes; it snoops accepted writes. */
`timescale 1ns/1ps
`default_nettype none
module global_status_gpio_control_monitor
  import global_status_pkg::*;
#(
  parameter int PORTS = 4
) (
  input wire logic             sys_clk,               // clock
  input wire logic             sys_rst,               // reset
  input wire logic [3:0]       avs_address,           // word address
  input wire logic             avs_read,              // read
  input wire logic             avs_write,             // write
  input wire logic [31:0]      avs_writedata,         // write data
  input wire logic [31:0]      avs_readdata,          // read data
  input wire logic             avs_waitrequest,       // stall
  input wire logic [PORTS-1:0] port_los,              // port LOS
  input wire logic [PORTS-1:0] port_irq_active,       // port status
  input wire logic             one_second_ref,        // timer
  input wire gpio_bus_s        gpio_out,              // pin values
  input wire gpio_bus_s        gpio_oe,               // pin enables
  input wire logic             manual_error_insert,   // error strobe
  input wire logic             global_update_request, // update level
  input wire logic             irq_n_out,             // irq value
  input wire logic             irq_n_oe               // irq enable
);
  logic [15:0] sel_q, ctrl_q, ie_q, sel_p, ctrl_p;
  logic [3:0]  los_p, oe_x, out_x;
  logic        sec_p;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // shadow config, updated at the accepting edge like the design
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= 16'h0000;
      ctrl_q <= 16'h0000;
      ie_q <= 16'h0000;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == OFS_GIOCR[5:2]) sel_q <= avs_writedata[15:0];
      if (avs_address == OFS_CTRL[5:2])
        ctrl_q <= avs_writedata[15:0] & CTRL_MASK;
      if (avs_address == OFS_ISRIE[5:2])
        ie_q <= avs_writedata[15:0] & ISRIE_MASK;
    end
  end
  // one-cycle copies: pin outputs are registered from these
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_p <= 16'h0000;
      ctrl_p <= 16'h0000;
      los_p <= 4'h0;
      sec_p <= 1'b0;
    end else begin
      sel_p <= sel_q;
      ctrl_p <= ctrl_q;
      los_p <= port_los[3:0];
      sec_p <= one_second_ref;
    end
  end
  // expected A-pin enables and values
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      oe_x[i] = sel_p[8+2*i +: 2] != FN_INPUT;
      out_x[i] = (sel_p[8+2*i +: 2] == FN_LOS) ? los_p[i]
                 : (sel_p[8+2*i +: 2] == FN_ONE);
    end
  end
  AST_BUS_ANS: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer after one wait cycle");
  AST_BUS_IDLE: assert property (!(avs_read || avs_write)
    |-> !avs_waitrequest) else $error("stall with no request");
  AST_RD_HOLE: assert property (avs_read && !avs_waitrequest
    && avs_address == 4'hF |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  AST_PIN_A: assert property (gpio_oe.a == oe_x &&
    (gpio_out.a & oe_x) == (out_x & oe_x)) else $error("A pin function");
  AST_PIN_B4: assert property (gpio_oe.b[3] == (sel_p[7:6] != FN_INPUT)
    && (!gpio_oe.b[3] || gpio_out.b[3] ==
    ((sel_p[7:6] == FN_LOS) ? los_p[3] : (sel_p[7:6] == FN_ONE))))
    else $error("B4 pin function");
  AST_B3_REF: assert property (ctrl_p[CTL_SEC_OE] |->
    gpio_oe.b[2] && gpio_out.b[2] == sec_p) else $error("B3 override");
  AST_ERR_SW: assert property (!ctrl_p[CTL_ERR_SRC] |->
    manual_error_insert == ctrl_p[CTL_ERR_INS]) else $error("error src");
  AST_UPD_SW: assert property (ctrl_p[5:4] == UPD_SW |->
    global_update_request == ctrl_p[CTL_UPD_REQ]) else $error("update");
  AST_IRQ_PORT: assert property (|(port_irq_active[3:0] & ie_q[4:1])
    |=> !irq_n_out) else $error("port irq missed");
  AST_IRQ_MASK: assert property (ie_q == 16'h0000 |=> irq_n_out)
    else $error("masked irq driven");
  AST_IRQ_PIN: assert property (irq_n_oe ==
    (!irq_n_out || ctrl_q[CTL_IRQ_IDLE])) else $error("irq pin drive");
  cover property (avs_write && !avs_waitrequest);
  cover property (!irq_n_out);
  cover property (ctrl_p[CTL_SEC_OE] && gpio_out.b[2]);
endmodule // global_status_gpio_control_monitor
bind global_status_gpio_control global_status_gpio_control_monitor
  #(.PORTS(PORTS)) mon_inst (.sys_clk, .sys_rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .port_los, .port_irq_active, .one_second_ref, .gpio_out, .gpio_oe,
  .manual_error_insert, .global_update_request, .irq_n_out, .irq_n_oe);
`default_nettype wire

// ### board_pins.sv
/* Board side of the general-purpose pins.
   Assumes the board drives every pin the device leaves undriven. */
`timescale 1ns/1ps
`default_nettype none
module board_pins
  import global_status_pkg::*;
(
  input wire gpio_bus_s  dev_out, // device values
  input wire gpio_bus_s  dev_oe,  // device enables
  input wire logic [7:0] drv,     // board levels
  output gpio_bus_s      pad      // resolved pads
);
  // device wins where enabled, board elsewhere
  assign pad = gpio_bus_s'((dev_out & dev_oe) | (drv & ~dev_oe));
endmodule // board_pins
`default_nettype wire

// ### global_status_gpio_control_tb.sv
/* Testbench for the global status and pin block.
   Assumes one-wait-cycle Avalon answers and a board pin model. */
`timescale 1ns/1ps
`default_nettype none
module global_status_gpio_control_tb;
  import global_status_pkg::*;
  logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 0, avs_readdata, rdat;
  logic avs_waitrequest, manual_error_insert, global_update_request;
  logic [3:0] port_los = 4'h5, port_irq_active = 0, o;
  logic [3:0] port_update_mode = 4'h3, port_update_done = 4'h1;
  logic adapter_unlocked = 0, one_second_ref = 0, irq_n_out, irq_n_oe;
  logic adapter_reference_clock = 0, adapter_clock_a = 0;
  logic adapter_clock_b = 0, adapter_clock_c = 0;
  logic [7:0] board_drv = 8'hA5;
  logic [1:0] c;
  gpio_bus_s gpio_in, gpio_out, gpio_oe;
  int num_errors = 0, checks_done = 0;
  global_status_gpio_control #(.PORTS(4)) global_status_gpio_control_inst (
    .sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .port_los, .port_irq_active, .port_update_mode, .port_update_done,
    .adapter_unlocked, .one_second_ref, .adapter_reference_clock,
    .adapter_clock_a, .adapter_clock_b, .adapter_clock_c, .gpio_in,
    .gpio_out, .gpio_oe, .manual_error_insert, .global_update_request,
    .irq_n_out, .irq_n_oe);
  board_pins board_pins_inst (.dev_out(gpio_out), .dev_oe(gpio_oe),
    .drv(board_drv), .pad(gpio_in));
  always #2 sys_clk = ~sys_clk;
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus cycle; request held until waitrequest is seen low
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [15:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a[5:2];
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    // look at the settled stall between edges, never at the edge itself
    do begin
      @(negedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    @(posedge sys_clk);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(rdat, {16'h0000, e});
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  initial begin
    tk(2);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, RST_CTRL);
    rd(OFS_GIOCR, RST_GIOCR);
    rd(OFS_ISRIE, RST_ISRIE);
    rd(OFS_SRIE, RST_SRIE);
    rd(6'h3C, 16'h0000);
    wr(OFS_ISR, 16'h001F);
    rd(OFS_ISR, 16'h0000);
    wr(OFS_SRL, 16'h007F);
    rd(OFS_SRL, 16'h0000);
    // every selector code on all eight pins at once
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      o = (c == FN_LOS) ? port_los : {4{c == FN_ONE}};
      wr(OFS_GIOCR, {8{c}});
      tk(3);
      chk({gpio_oe, gpio_out & gpio_oe}, {{8{c != 0}}, o, o});
      rd(OFS_PIN, {8'h00, c == 0 ? board_drv : {o, o}});
    end
    // B3 still drives one: override must show the timer level
    wr(OFS_CTRL, 16'h0004);
    one_second_ref <= 1'b1;
    tk(3);
    chk({gpio_oe.b[2], gpio_out.b[2]}, 2'b11);
    one_second_ref <= 1'b0;
    tk(3);
    chk({gpio_oe.b[2], gpio_out.b[2]}, 2'b10);
    rd(OFS_SRL, 16'h0002);
    wr(OFS_SRL, 16'h007F);
    wr(OFS_GIOCR, 16'h0000);
    wr(OFS_CTRL, 16'h0008);
    board_drv <= 8'h02;
    tk(5);
    chk(manual_error_insert, 1'b1);
    board_drv <= 8'h00;
    tk(5);
    chk(manual_error_insert, 1'b0);
    wr(OFS_CTRL, 16'h0010);
    board_drv <= 8'h01;
    tk(5);
    chk(global_update_request, 1'b1);
    board_drv <= 8'h00;
    tk(5);
    chk(global_update_request, 1'b0);
    // software update: held until done, ports 3 and 4 not global
    wr(OFS_CTRL, 16'h0040);
    port_update_done <= 4'h5;
    tk(2);
    rd(OFS_SR, 16'h0000);
    port_update_done <= 4'h3;
    tk(2);
    rd(OFS_SR, 16'h0001);
    rd(OFS_SRL, 16'h0001);
    wr(OFS_CTRL, 16'h0000);
    tk(2);
    rd(OFS_SR, 16'h0000);
    wr(OFS_SRL, 16'h007F);
    adapter_unlocked <= 1'b1;
    tk(2);
    rd(OFS_SR, 16'h0004);
    adapter_unlocked <= 1'b0;
    tk(2);
    rd(OFS_SRL, 16'h0004);
    chk(irq_n_out, 1'b1);
    wr(OFS_SRIE, 16'h0004);
    wr(OFS_ISRIE, 16'h0001);
    tk(2);
    chk({irq_n_out, irq_n_oe}, 2'b01);
    rd(OFS_ISR, 16'h0001);
    wr(OFS_SRL, 16'h007F);
    tk(2);
    chk({irq_n_out, irq_n_oe}, 2'b10);
    wr(OFS_CTRL, 16'h0002);
    tk(2);
    chk({irq_n_out, irq_n_oe}, 2'b11);
    port_irq_active <= 4'h8;
    tk(2);
    rd(OFS_ISR, 16'h0010);
    chk(irq_n_out, 1'b1);
    wr(OFS_ISRIE, 16'h0010);
    tk(2);
    chk(irq_n_out, 1'b0);
    port_irq_active <= 4'h0;
    // clear on read; then activity latches in both adapter modes
    wr(OFS_CTRL, 16'h0001);
    one_second_ref <= 1'b1;
    tk(2);
    one_second_ref <= 1'b0;
    rd(OFS_SRL, 16'h0002);
    rd(OFS_SRL, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      wr(OFS_CTRL, {5'h00, 3'(j), 8'h01});
      repeat (4) begin
        adapter_clock_a <= !adapter_clock_a;
        adapter_clock_b <= !adapter_clock_b;
        adapter_clock_c <= !adapter_clock_c;
        adapter_reference_clock <= !adapter_reference_clock;
        tk(2);
      end
      tk(3);
      rd(OFS_SRL, j ? 16'h0008 : 16'h0070);
    end
    test_done();
  end
endmodule // global_status_gpio_control_tb
`default_nettype wire
